// ==== include/ciss_pkg.sv ====
// shared constants, opcodes and carrier types for the instruction slice executor
package ciss_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int TPTR_W = 21;
  localparam int HOLD_N = 8;
  localparam int HOLD_IDX_W = 3;
  localparam int FSR_N = 3;
  localparam int FSR_SEL_W = 2;
  localparam int BANK_W = 4;
  localparam int LIT6_W = 6;

  // opcode patterns, compared against the upper bits of the word, or against the whole word for OPC_CALL_ACC
  localparam logic [5:0] OPC_SUB_BORROW = 6'h16;
  localparam logic [5:0] OPC_XOR_FILE = 6'h06;
  localparam logic [5:0] OPC_NIBBLE_SWAP = 6'h0e;
  localparam logic [7:0] OPC_XOR_LIT = 8'h0a;
  localparam logic [13:0] OPC_TABLE_WRITE = 14'h0003;
  localparam logic [7:0] OPC_PTR_ADD = 8'he8;
  localparam logic [7:0] OPC_PTR_SUB = 8'he9;
  localparam logic [7:0] OPC_IDX_MOVE = 8'heb;
  localparam logic [7:0] OPC_PUSH_LIT = 8'hfa;
  localparam logic [15:0] OPC_CALL_ACC = 16'h0014;

  // operand field positions
  localparam int BIT_DEST = 9;
  localparam int BIT_ACCESS = 8;
  localparam int FSR_SEL_LSB = 6;

  // addressing constants
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [1:0] FRAME_SEL = 2'h3;
  localparam logic [1:0] FRAME_FSR = 2'h2;

  // table write pointer handling codes
  localparam logic [1:0] TW_KEEP = 2'h0;
  localparam logic [1:0] TW_POST_INC = 2'h1;
  localparam logic [1:0] TW_POST_DEC = 2'h2;
  localparam logic [1:0] TW_PRE_INC = 2'h3;

  // reset values
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [20:0] RST_TPTR = 21'h000000;
  localparam logic [7:0] RST_HOLD = 8'hff;
  localparam logic [11:0] RST_FSR = 12'h000;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } ciss_status_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ciss_mem_req_t;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} ciss_phase_t;

  typedef enum logic [3:0] {
    OP_NOP, OP_SUBB, OP_XORF, OP_XORL, OP_SWAP, OP_TABLE_WRITE_INSTR, OP_PTRADD, OP_PTRSUB, OP_EXT_OTHER
  } ciss_op_t;

endpackage : ciss_pkg

// ==== rtl/ciss_addr_gen.sv ====
// data address generation for file-register operands
`timescale 1ns/10ps
module ciss_addr_gen (
  input wire logic [7:0] file_addr, // 8-bit file field
  input wire logic access_bit, // 0 access bank, 1 banked
  input wire logic [3:0] bank_sel, // current bank pointer
  input wire logic ext_en, // extended set active
  input wire logic [11:0] frame_ptr, // stack frame pointer
  output logic [11:0] data_addr, // resolved data address
  output logic indexed // literal offset mode used
);

  always_comb begin
    // [RULE4] indexed literal offset
    indexed = ext_en && !access_bit && (file_addr <= ciss_pkg::IDX_LIMIT);
    if (indexed) begin
      data_addr = frame_ptr + {4'h0, file_addr};
    end else if (access_bit) begin
      // [RULE3] banked via pointer
      data_addr = {bank_sel, file_addr};
    end else if (file_addr < ciss_pkg::ACCESS_SPLIT) begin
      data_addr = {ciss_pkg::ACCESS_LO_BANK, file_addr};
    end else begin
      // upper half of access bank maps onto the special registers
      data_addr = {ciss_pkg::ACCESS_HI_BANK, file_addr};
    end
  end

endmodule : ciss_addr_gen

// ==== rtl/ciss_exec.sv ====
// execution unit for a slice of the 8-bit core instruction set
`timescale 1ns/10ps
// Overview of operation
// [RULE1] subtract-with-borrow: file minus accumulator minus borrow
// [RULE2] destination bit picks accumulator or file
// [RULE3] access bit picks access bank or bank
// [RULE4] extended, access bank, address<=95: indexed offset
// [RULE5] borrow subtract sets five flags, one cycle
// [RULE6] xor with file, sign/zero flags, one cycle
// [RULE7] xor literal into accumulator, sign/zero flags
// [RULE8] pointer low three bits choose holding register
// [RULE9] low opcode bits: keep, post-inc, post-dec, pre-inc
// [RULE10] table pointer is a 21-bit byte address
// [RULE11] table write: two cycles, latch Q2, write Q4
// [RULE12] extended features off unless fuse set
// [RULE13] frame add/sub variants also perform a return
// [RULE14] other extended instructions are pointer literal ops; the code runs only the add/sub ones and flags the rest on ext_unhandled_q
// [RULE15] nibble swap of file register, routed by destination
// [RULE16] holding register keeps value until programming consumes it
module ciss_exec (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset
  input wire logic ce, // clock enable, freezes all state
  input wire logic extension_enable_fuse, // config bit, caught after reset
  input wire logic instr_valid, // instruction word present in Q1
  input wire logic [15:0] instr_word, // instruction word
  input wire logic [3:0] bank_pointer, // bank select
  input wire logic acc_load, // software load of accumulator
  input wire logic [7:0] acc_wdata, // accumulator load value
  input wire logic status_load, // software load of flags
  input wire ciss_pkg::ciss_status_t status_wdata, // flag load value
  input wire logic [7:0] table_latch, // table latch byte
  input wire logic tptr_load, // software load of table pointer
  input wire logic [20:0] tptr_wdata, // table pointer load value
  input wire logic fsr_load, // software load of a file select pointer
  input wire logic [1:0] fsr_sel, // pointer to load
  input wire logic [11:0] fsr_wdata, // pointer load value
  input wire logic [7:0] mem_rdata, // data memory read data, valid in Q3
  output ciss_pkg::ciss_mem_req_t mem_req_q, // data memory request
  output logic instr_ready_q, // an instruction is taken this Q1
  output logic [7:0] acc_q, // accumulator
  output ciss_pkg::ciss_status_t status_q, // flags
  output logic [20:0] table_pointer_q, // table pointer
  output logic [7:0][7:0] hold_q, // holding registers
  output logic [2:0][11:0] fsr_q, // file select pointers
  output logic frame_return_q, // one-clock return request
  output logic ext_unhandled_q, // extended op outside this slice
  output logic ext_active_q // extended set enabled
);

  ciss_pkg::ciss_phase_t phase_q;
  ciss_pkg::ciss_op_t op_q;
  ciss_pkg::ciss_op_t op_d;
  logic [15:0] iw_q;
  logic second_q;
  logic cfg_done_q;
  logic [7:0] res_q;
  ciss_pkg::ciss_status_t flag_q;
  logic [7:0] tl_q;
  logic [11:0] agen_addr;
  logic take;
  logic two_cycle;
  logic [10:0] sub_out;
  logic [1:0] ptr_idx;
  logic [20:0] tw_idx_ptr;
  logic [7:0] alu_res;

  function automatic ciss_pkg::ciss_op_t decode_op(input logic [15:0] w, input logic ext);
    decode_op = ciss_pkg::OP_NOP;
    if (w[15:10] == ciss_pkg::OPC_SUB_BORROW) begin
      decode_op = ciss_pkg::OP_SUBB;
    end else if (w[15:10] == ciss_pkg::OPC_XOR_FILE) begin
      decode_op = ciss_pkg::OP_XORF;
    end else if (w[15:10] == ciss_pkg::OPC_NIBBLE_SWAP) begin
      decode_op = ciss_pkg::OP_SWAP;
    end else if (w[15:8] == ciss_pkg::OPC_XOR_LIT) begin
      decode_op = ciss_pkg::OP_XORL;
    end else if (w[15:2] == ciss_pkg::OPC_TABLE_WRITE) begin
      decode_op = ciss_pkg::OP_TABLE_WRITE_INSTR;
    end else if (ext) begin
      // [RULE14] pointer literal ops vs the rest
      if (w[15:8] == ciss_pkg::OPC_PTR_ADD) begin
        decode_op = ciss_pkg::OP_PTRADD;
      end else if (w[15:8] == ciss_pkg::OPC_PTR_SUB) begin
        decode_op = ciss_pkg::OP_PTRSUB;
      end else if (w[15:8] == ciss_pkg::OPC_IDX_MOVE || w[15:8] == ciss_pkg::OPC_PUSH_LIT ||
                   w == ciss_pkg::OPC_CALL_ACC) begin
        decode_op = ciss_pkg::OP_EXT_OTHER;
      end
    end
  endfunction : decode_op

  function automatic logic is_file_op(input ciss_pkg::ciss_op_t op);
    is_file_op = (op == ciss_pkg::OP_SUBB) || (op == ciss_pkg::OP_XORF) ||
                 (op == ciss_pkg::OP_SWAP);
  endfunction : is_file_op

  // returns {ov, dc, c, result}
  function automatic logic [10:0] sub_borrow(input logic [7:0] f, input logic [7:0] w,
                                             input logic c);
    logic [8:0] full;
    logic [4:0] lo;
    logic ov;
    full = {1'b0, f} + {1'b0, ~w} + {8'h00, c};
    lo = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + {4'h0, c};
    ov = (f[7] ^ w[7]) & (full[7] ^ f[7]);
    sub_borrow = {ov, lo[4], full[8], full[7:0]};
  endfunction : sub_borrow

  ciss_addr_gen u_agen (
    .file_addr(instr_word[7:0]),
    .access_bit(instr_word[ciss_pkg::BIT_ACCESS]),
    .bank_sel(bank_pointer),
    .ext_en(ext_active_q),
    .frame_ptr(fsr_q[ciss_pkg::FRAME_FSR]),
    .data_addr(agen_addr),
    .indexed()
  );

  assign op_d = decode_op(instr_word, ext_active_q);
  assign take = (phase_q == ciss_pkg::PH_Q1) && !second_q;
  // [RULE11] [RULE13] two-cycle instructions
  assign two_cycle = (op_q == ciss_pkg::OP_TABLE_WRITE_INSTR) ||
                     ((op_q == ciss_pkg::OP_PTRADD || op_q == ciss_pkg::OP_PTRSUB) &&
                      iw_q[7:6] == ciss_pkg::FRAME_SEL);
  // [RULE1] borrow subtract datapath
  assign sub_out = sub_borrow(mem_rdata, acc_q, status_q.c);
  assign ptr_idx = (iw_q[7:6] == ciss_pkg::FRAME_SEL) ? ciss_pkg::FRAME_FSR : iw_q[7:6];
  // [RULE9] pre-increment indexes with the new pointer
  assign tw_idx_ptr = (iw_q[1:0] == ciss_pkg::TW_PRE_INC) ? table_pointer_q + 21'h000001
                                                           : table_pointer_q;

  // [RULE12] fuse caught once after reset release
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_done_q <= 1'b0;
      ext_active_q <= 1'b0;
    end else if (ce && !cfg_done_q) begin
      cfg_done_q <= 1'b1;
      ext_active_q <= extension_enable_fuse;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= ciss_pkg::PH_Q1;
    end else if (ce) begin
      case (phase_q)
        ciss_pkg::PH_Q1: phase_q <= ciss_pkg::PH_Q2;
        ciss_pkg::PH_Q2: phase_q <= ciss_pkg::PH_Q3;
        ciss_pkg::PH_Q3: phase_q <= ciss_pkg::PH_Q4;
        default: phase_q <= ciss_pkg::PH_Q1;
      endcase
    end
  end

  // decode in Q1; a second cycle holds the captured instruction
  always_ff @(posedge clk) begin
    if (rst) begin
      op_q <= ciss_pkg::OP_NOP;
      iw_q <= 16'h0000;
      second_q <= 1'b0;
      instr_ready_q <= 1'b1;
    end else if (ce) begin
      if (take) begin
        op_q <= instr_valid ? op_d : ciss_pkg::OP_NOP;
        iw_q <= instr_word;
      end
      if (phase_q == ciss_pkg::PH_Q4) begin
        second_q <= two_cycle && !second_q;
        instr_ready_q <= !(two_cycle && !second_q);
      end else begin
        instr_ready_q <= 1'b0;
      end
    end
  end

  // read strobe in Q2, write strobe in Q4
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_req_q <= '0;
    end else if (ce) begin
      case (phase_q)
        ciss_pkg::PH_Q1: begin
          mem_req_q.rd <= take && instr_valid && is_file_op(op_d);
          mem_req_q.addr <= agen_addr;
        end
        ciss_pkg::PH_Q2: mem_req_q.rd <= 1'b0;
        ciss_pkg::PH_Q3: begin
          // [RULE2] destination bit one writes the file
          mem_req_q.wr <= is_file_op(op_q) && iw_q[ciss_pkg::BIT_DEST];
        end
        default: mem_req_q.wr <= 1'b0;
      endcase
      // taken with the result, so it stands for the whole Q4 write strobe
      if (phase_q == ciss_pkg::PH_Q3) begin
        mem_req_q.wdata <= alu_res;
      end
    end
  end

  // one result feeds both the result register and the write data
  always_comb begin
    case (op_q)
      ciss_pkg::OP_SUBB: alu_res = sub_out[7:0];
      // [RULE6] xor with file
      ciss_pkg::OP_XORF: alu_res = acc_q ^ mem_rdata;
      // [RULE7] xor with literal
      ciss_pkg::OP_XORL: alu_res = acc_q ^ iw_q[7:0];
      // [RULE15] nibble swap, no flags
      ciss_pkg::OP_SWAP: alu_res = {mem_rdata[3:0], mem_rdata[7:4]};
      default: alu_res = res_q;
    endcase
  end

  // result and flag candidates formed in Q3
  always_ff @(posedge clk) begin
    if (rst) begin
      res_q <= 8'h00;
      flag_q <= '0;
    end else if (ce && phase_q == ciss_pkg::PH_Q3) begin
      res_q <= alu_res;
      flag_q <= status_q;
      case (op_q)
        ciss_pkg::OP_SUBB: begin
          flag_q.ov <= sub_out[10];
          flag_q.dc <= sub_out[9];
          flag_q.c <= sub_out[8];
          flag_q.n <= sub_out[7];
          flag_q.z <= (sub_out[7:0] == 8'h00);
        end
        // [RULE6] [RULE7] sign and zero only
        ciss_pkg::OP_XORF, ciss_pkg::OP_XORL: begin
          flag_q.n <= alu_res[7];
          flag_q.z <= (alu_res == 8'h00);
        end
        default: flag_q <= status_q;
      endcase
    end
  end

  // [RULE5] accumulator and flags retire at end of Q4
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= ciss_pkg::RST_ACC;
      status_q <= '0;
    end else if (ce) begin
      if (phase_q == ciss_pkg::PH_Q4 && !second_q &&
          (op_q == ciss_pkg::OP_XORL || (is_file_op(op_q) && !iw_q[ciss_pkg::BIT_DEST]))) begin
        // [RULE2] destination bit zero writes accumulator
        acc_q <= res_q;
      end else if (acc_load) begin
        acc_q <= acc_wdata;
      end
      if (phase_q == ciss_pkg::PH_Q4 && !second_q &&
          (op_q == ciss_pkg::OP_SUBB || op_q == ciss_pkg::OP_XORF ||
           op_q == ciss_pkg::OP_XORL)) begin
        status_q <= flag_q;
      end else if (status_load) begin
        status_q <= status_wdata;
      end
    end
  end

  // [RULE11] latch read in Q2, holding write in Q4 of second cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      tl_q <= 8'h00;
      hold_q <= {ciss_pkg::HOLD_N{ciss_pkg::RST_HOLD}};
      table_pointer_q <= ciss_pkg::RST_TPTR;
    end else if (ce) begin
      if (second_q && op_q == ciss_pkg::OP_TABLE_WRITE_INSTR && phase_q == ciss_pkg::PH_Q2) begin
        tl_q <= table_latch;
      end
      if (second_q && op_q == ciss_pkg::OP_TABLE_WRITE_INSTR && phase_q == ciss_pkg::PH_Q4) begin
        // [RULE8] [RULE16] indexed holding write, kept until consumed
        hold_q[tw_idx_ptr[ciss_pkg::HOLD_IDX_W-1:0]] <= tl_q;
        // [RULE9] [RULE10] pointer update, wraps in 21 bits
        case (iw_q[1:0])
          ciss_pkg::TW_POST_INC: table_pointer_q <= table_pointer_q + 21'h000001;
          ciss_pkg::TW_POST_DEC: table_pointer_q <= table_pointer_q - 21'h000001;
          ciss_pkg::TW_PRE_INC: table_pointer_q <= tw_idx_ptr;
          default: table_pointer_q <= table_pointer_q;
        endcase
      end else if (tptr_load) begin
        table_pointer_q <= tptr_wdata;
      end
    end
  end

  // pointer literal ops and frame variants with return
  always_ff @(posedge clk) begin
    if (rst) begin
      fsr_q <= {ciss_pkg::FSR_N{ciss_pkg::RST_FSR}};
      frame_return_q <= 1'b0;
      ext_unhandled_q <= 1'b0;
    end else if (ce) begin
      frame_return_q <= 1'b0;
      ext_unhandled_q <= (phase_q == ciss_pkg::PH_Q1) && take && instr_valid &&
                         (op_d == ciss_pkg::OP_EXT_OTHER);
      if (phase_q == ciss_pkg::PH_Q4 && !second_q && op_q == ciss_pkg::OP_PTRADD) begin
        fsr_q[ptr_idx] <= fsr_q[ptr_idx] + {6'h00, iw_q[5:0]};
        // [RULE13] frame add then return
        frame_return_q <= (iw_q[7:6] == ciss_pkg::FRAME_SEL);
      end else if (phase_q == ciss_pkg::PH_Q4 && !second_q &&
                   op_q == ciss_pkg::OP_PTRSUB) begin
        fsr_q[ptr_idx] <= fsr_q[ptr_idx] - {6'h00, iw_q[5:0]};
        // [RULE13] frame sub then return
        frame_return_q <= (iw_q[7:6] == ciss_pkg::FRAME_SEL);
      end else if (fsr_load && fsr_sel != ciss_pkg::FRAME_SEL) begin
        fsr_q[fsr_sel] <= fsr_wdata;
      end
    end
  end

  default clocking dcb @(posedge clk); endclocking
  default disable iff (rst);

  a_subb_result: assert property ( // [RULE1]
    (ce && phase_q == ciss_pkg::PH_Q3 && op_q == ciss_pkg::OP_SUBB) |=>
      res_q == 8'($past(mem_rdata) - $past(acc_q) - {7'h00, !$past(status_q.c)}))
    else $error("borrow subtract result wrong");
  a_dest_file_wr: assert property ( // [RULE2]
    (phase_q == ciss_pkg::PH_Q4 && is_file_op(op_q) && iw_q[ciss_pkg::BIT_DEST]) |->
      mem_req_q.wr && mem_req_q.wdata == res_q)
    else $error("file destination not written in Q4");
  a_bank_addr: assert property ( // [RULE3]
    (ce && take && instr_valid && is_file_op(op_d) && instr_word[ciss_pkg::BIT_ACCESS]) |=>
      mem_req_q.rd && mem_req_q.addr == {$past(bank_pointer), $past(instr_word[7:0])})
    else $error("banked address wrong");
  a_indexed_addr: assert property ( // [RULE4]
    (ce && take && instr_valid && is_file_op(op_d) && ext_active_q &&
     !instr_word[ciss_pkg::BIT_ACCESS] && instr_word[7:0] <= ciss_pkg::IDX_LIMIT) |=>
      mem_req_q.addr == 12'($past(fsr_q[ciss_pkg::FRAME_FSR]) + {4'h0, $past(instr_word[7:0])}))
    else $error("indexed offset address wrong");
  a_xorl_result: assert property ( // [RULE7]
    (ce && phase_q == ciss_pkg::PH_Q3 && op_q == ciss_pkg::OP_XORL) ##1
      (ce && phase_q == ciss_pkg::PH_Q4) |=> acc_q == ($past(acc_q, 2) ^ $past(iw_q[7:0], 2)))
    else $error("xor literal not in accumulator");
  a_swap_nibbles: assert property ( // [RULE15]
    (ce && phase_q == ciss_pkg::PH_Q3 && op_q == ciss_pkg::OP_SWAP) |=>
      res_q == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
    else $error("nibble swap wrong");
  a_hold_write: assert property ( // [RULE8]
    (ce && second_q && op_q == ciss_pkg::OP_TABLE_WRITE_INSTR && phase_q == ciss_pkg::PH_Q4 &&
     iw_q[1:0] == ciss_pkg::TW_POST_INC) |=>
      hold_q[$past(table_pointer_q[2:0])] == $past(tl_q) &&
      table_pointer_q == 21'($past(table_pointer_q) + 21'h000001))
    else $error("table write post-increment wrong");
  a_ext_off: assert property ( // [RULE12]
    (ce && take && !ext_active_q) |=> op_q != ciss_pkg::OP_PTRADD &&
      op_q != ciss_pkg::OP_PTRSUB && op_q != ciss_pkg::OP_EXT_OTHER)
    else $error("extended op decoded while disabled");
  a_frame_return: assert property ( // [RULE13]
    frame_return_q |-> second_q && phase_q == ciss_pkg::PH_Q1)
    else $error("return request outside second cycle");

endmodule : ciss_exec

// ==== verification/ciss_mem_model.sv ====
// data memory model standing behind the executor's memory request port
`timescale 1ns/10ps
module ciss_mem_model (
  input wire logic clk, // core clock
  input wire ciss_pkg::ciss_mem_req_t req, // request from the executor
  output logic [7:0] rdata // read data, valid the clock after rd
);
  logic [7:0] mem [4096];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
    rdata = 8'h00;
  end
  // read in Q2, write in Q4
  always @(posedge clk) begin
    // released bus toggles so a late sample never sees stale data
    if (req.rd === 1'b1) rdata <= mem[req.addr];
    else rdata <= ~rdata;
    if (req.wr === 1'b1) mem[req.addr] <= req.wdata;
  end
endmodule : ciss_mem_model

// ==== verification/cpu_instruction_subset_exec_test.sv ====
// self-checking bench for the instruction slice executor
`timescale 1ns/10ps
module cpu_instruction_subset_exec_test;
  logic clk, rst, ce, fuse, iv, acc_ld, st_ld, tp_ld, fsr_ld, ready, fret, unh, ext_q;
  logic [15:0] iw;
  logic [3:0] bank;
  logic [7:0] acc_wd, tlat, rdata, acc_q, wr_d, m_acc;
  ciss_pkg::ciss_status_t st_wd, status_q, m_st;
  logic [20:0] tp_wd, tptr_q, m_tp;
  logic [1:0] fsr_s;
  logic [11:0] fsr_wd, rd_a, wr_a;
  ciss_pkg::ciss_mem_req_t req;
  logic [7:0][7:0] hold_q;
  logic [2:0][11:0] fsr_q;
  logic [7:0] m_hold [8];
  logic [11:0] m_fsr [3];
  logic [7:0] m_mem [4096];
  logic m_ext;
  logic [31:0] seed;
  int err_count, n_checks, n_wr, n_ret, n_unh, n_rdy;

  ciss_exec dut (.clk(clk), .rst(rst), .ce(ce), .extension_enable_fuse(fuse),
    .instr_valid(iv), .instr_word(iw), .bank_pointer(bank), .acc_load(acc_ld),
    .acc_wdata(acc_wd), .status_load(st_ld), .status_wdata(st_wd), .table_latch(tlat),
    .tptr_load(tp_ld), .tptr_wdata(tp_wd), .fsr_load(fsr_ld), .fsr_sel(fsr_s),
    .fsr_wdata(fsr_wd), .mem_rdata(rdata), .mem_req_q(req), .instr_ready_q(ready),
    .acc_q(acc_q), .status_q(status_q), .table_pointer_q(tptr_q), .hold_q(hold_q),
    .fsr_q(fsr_q), .frame_return_q(fret), .ext_unhandled_q(unh), .ext_active_q(ext_q));
  ciss_mem_model mem_i (.clk(clk), .req(req), .rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (req.rd === 1'b1) rd_a <= req.addr;
    if (req.wr === 1'b1) begin
      n_wr <= n_wr + 1;
      wr_a <= req.addr;
      wr_d <= req.wdata;
    end
    if (fret === 1'b1) n_ret <= n_ret + 1;
    if (unh === 1'b1) n_unh <= n_unh + 1;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 16; i++) begin
      s = s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
    end
    return s;
  endfunction : lfsr

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  // waits for the take edge, then the whole instruction plus one edge
  task automatic run(input logic [15:0] w, input int cyc);
    int k;
    k = 0;
    iv <= 1'b1;
    iw <= w;
    do begin
      @(posedge clk);
      k++;
    end while (ready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_count++;
      $display("unexpected at %0t: instruction never taken", $time);
      conclude();
    end
    iv <= 1'b0;
    n_wr = 0;
    n_ret = 0;
    n_unh = 0;
    n_rdy = 0;
    repeat (cyc * 4 + 1) begin
      @(posedge clk);
      n_rdy += (ready === 1'b1);
    end
  endtask : run

  task automatic do_reset(input logic fz);
    rst <= 1'b1;
    fuse <= fz;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    m_acc = 8'h00;
    m_st = '0;
    m_tp = 21'h000000;
    m_ext = fz;
    for (int j = 0; j < 8; j++) m_hold[j] = 8'hff;
    for (int j = 0; j < 3; j++) m_fsr[j] = 12'h000;
    chk("reset acc", acc_q, m_acc);
    chk("reset tptr", tptr_q, m_tp);
    for (int j = 0; j < 8; j++) chk("reset hold", hold_q[j], m_hold[j]);
  endtask : do_reset

  task automatic preset(input logic [7:0] a, input ciss_pkg::ciss_status_t s,
                        input logic [20:0] t, input logic [11:0] f, input logic [1:0] i);
    acc_ld <= 1'b1;
    acc_wd <= a;
    st_ld <= 1'b1;
    st_wd <= s;
    tp_ld <= 1'b1;
    tp_wd <= t;
    fsr_ld <= 1'b1;
    fsr_s <= i;
    fsr_wd <= f;
    @(posedge clk);
    {acc_ld, st_ld, tp_ld, fsr_ld} <= 4'h0;
    m_acc = a;
    m_st = s;
    m_tp = t;
    m_fsr[i] = f;
  endtask : preset

  function automatic logic [11:0] ea(input logic [7:0] f, input logic a);
    if (m_ext && !a && f <= 8'h5f) return m_fsr[2] + 12'(f);
    if (a) return {bank, f};
    return f[7] ? {4'hf, f} : {4'h0, f};
  endfunction : ea

  // kind 0 borrow subtract, 1 xor with file, 2 nibble swap, 3 xor literal
  task automatic op(input logic [1:0] kind, input logic d, input logic a, input logic [7:0] f);
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] v, res;
    logic [11:0] ad;
    ad = ea(f, a);
    v = (kind == 2'h3) ? f : m_mem[ad];
    res = v ^ m_acc;
    if (kind == 2'h2) res = {v[3:0], v[7:4]};
    if (kind == 2'h0) begin
      r = {1'b0, v} + {1'b0, ~m_acc} + 9'(m_st.c);
      h = {1'b0, v[3:0]} + {1'b0, ~m_acc[3:0]} + 5'(m_st.c);
      res = r[7:0];
      {m_st.c, m_st.dc} = {r[8], h[4]};
      m_st.ov = (v[7] != m_acc[7]) && (res[7] != v[7]);
    end
    if (kind != 2'h2) {m_st.n, m_st.z} = {res[7], res == 8'h00};
    case (kind)
      2'h0: run({ciss_pkg::OPC_SUB_BORROW, d, a, f}, 1);
      2'h1: run({ciss_pkg::OPC_XOR_FILE, d, a, f}, 1);
      2'h2: run({ciss_pkg::OPC_NIBBLE_SWAP, d, a, f}, 1);
      default: run({ciss_pkg::OPC_XOR_LIT, f}, 1);
    endcase
    if (kind == 2'h3) d = 1'b0;
    else chk("read addr", rd_a, ad);
    chk("write count", n_wr, d);
    if (d) begin
      chk("write addr", wr_a, ad);
      chk("write data", wr_d, res);
      m_mem[ad] = res;
    end else begin
      m_acc = res;
    end
    chk("acc", acc_q, m_acc);
    chk("flags", status_q, m_st);
  endtask : op

  task automatic tw(input logic [1:0] m, input logic [7:0] lat);
    tlat <= lat;
    if (m == ciss_pkg::TW_PRE_INC) m_tp = m_tp + 21'h1;
    m_hold[m_tp[2:0]] = lat;
    if (m == ciss_pkg::TW_POST_INC) m_tp = m_tp + 21'h1;
    if (m == ciss_pkg::TW_POST_DEC) m_tp = m_tp - 21'h1;
    run({14'h0003, m}, 2);
    chk("table ptr", tptr_q, m_tp);
    chk("ready slots", n_rdy, 1);
    for (int j = 0; j < 8; j++) chk("hold", hold_q[j], m_hold[j]);
  endtask : tw

  task automatic ptr_op(input logic sub, input logic [1:0] ff, input logic [5:0] k);
    logic [1:0] i;
    logic fr;
    i = (ff == 2'h3) ? 2'h2 : ff;
    fr = m_ext && ff == 2'h3;
    if (m_ext) m_fsr[i] = sub ? m_fsr[i] - 12'(k) : m_fsr[i] + 12'(k);
    run({7'h74, sub, ff, k}, 2);
    for (int j = 0; j < 3; j++) chk("pointer", fsr_q[j], m_fsr[j]);
    chk("return pulse", n_ret, fr);
    chk("ready slots", n_rdy, fr ? 1 : 2);
    chk("acc kept", acc_q, m_acc);
  endtask : ptr_op

  task automatic others();
    logic [15:0] words [3];
    words = '{16'h0014, 16'heb00, 16'hfa00};
    for (int j = 0; j < 3; j++) begin
      run(words[j], 2);
      chk("unhandled pulse", n_unh, m_ext);
      chk("acc kept", acc_q, m_acc);
    end
  endtask : others

  initial begin
    {rst, ce, fuse, iv, acc_ld, st_ld, tp_ld, fsr_ld} = 8'hc0;
    {iw, bank, acc_wd, tlat, tp_wd, fsr_s, fsr_wd} = '0;
    st_wd = '0;
    {err_count, n_checks, n_wr, n_ret, n_unh, n_rdy} = '0;
    seed = 32'h00011180;
    for (int i = 0; i < 4096; i++) m_mem[i] = 8'(i) ^ 8'h5a;
    do_reset(1'b0);
    preset(8'h0d, 5'h01, 21'h000000, 12'h300, 2'h2);
    op(2'h0, 1'b1, 1'b0, 8'h43);
    chk("ext off", ext_q, 1'b0);
    ptr_op(1'b0, 2'h3, 6'h23);
    others();
    $display("test ext_off done");
    do_reset(1'b1);
    preset(8'h5a, 5'h00, 21'h000000, 12'h3ff, 2'h2);
    chk("ext on", ext_q, 1'b1);
    for (int j = 0; j < 8; j++) ptr_op(j[0], j[2:1] + 2'(j[0]), 6'(j * 9 + 1));
    ptr_op(1'b0, 2'h3, 6'h3f);
    op(2'h1, 1'b1, 1'b0, 8'h5f);
    op(2'h1, 1'b1, 1'b0, 8'h60);
    others();
    $display("test ext_on done");
    for (int n = 0; n < 60; n++) begin
      seed = lfsr(seed);
      bank <= seed[3:0];
      preset(seed[11:4], ciss_pkg::ciss_status_t'(seed[16:12]), m_tp, seed[31:20], 2'(n % 3));
      seed = lfsr(seed);
      op(seed[1:0], seed[2], seed[3], seed[15:8]);
    end
    $display("test random done");
    // clock enable low must freeze the accumulator against a load
    ce <= 1'b0;
    acc_ld <= 1'b1;
    acc_wd <= ~m_acc;
    repeat (3) @(posedge clk);
    {ce, acc_ld} <= 2'h2;
    @(posedge clk);
    chk("frozen acc", acc_q, m_acc);
    $display("test freeze done");
    preset(m_acc, m_st, 21'h1ffffe, 12'h000, 2'h0);
    for (int j = 0; j < 8; j++) tw(2'(j), 8'(j * 37 + 5));
    tw(2'h3, 8'h34);
    $display("test table done");
    conclude();
  end
endmodule : cpu_instruction_subset_exec_test
